// >>> bench/acpc_host_model.sv
// serial host model that drives the converter link and samples its output
`timescale 1ns/100ps
module acpc_host_model (
  input wire logic clk,
  input wire logic dout_pin,
  output logic cs_n_pin,
  output logic serial_bit_clock,
  output logic din_pin
);
  // ********************************
  // link timing and capture
  // ********************************
  // clk cycles per serial half period; the device syncs the serial clock
  // through two flops, so a slower link keeps every edge well apart
  localparam int HALF = 8;
  logic [31:0] rx; // bits seen at rising edges, newest in bit 0

  // idle state: deselected, clock parked low outside frames
  initial begin
    cs_n_pin = 1'b1;
    serial_bit_clock = 1'b0;
    din_pin = 1'b0;
    rx = '0;
  end

  // one frame of n clocks; pat goes out msb first, zeros after it
  task automatic run(input logic [23:0] pat, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      cs_n_pin <= 1'b0;
      din_pin <= (i < 24) ? pat[23-i] : 1'b0;
      repeat (HALF) @(posedge clk);
      serial_bit_clock <= 1'b1;
      rx <= {rx[30:0], dout_pin}; // sampled on the rise
      repeat (HALF) @(posedge clk);
      serial_bit_clock <= 1'b0;
    end
  endtask

  // deselect between frames so dout and busy stop driving; din toggles meanwhile
  task automatic stop();
    @(posedge clk);
    cs_n_pin <= 1'b1;
    din_pin <= ~din_pin;
    repeat (4) @(posedge clk);
  endtask
endmodule

// >>> bench/tb_adc_serial_conversion_power_control.sv
// bench top: apb access tasks and serial conversion scenarios
`timescale 1ns/100ps
module tb_adc_serial_conversion_power_control;
  // ********************************
  // signals and helpers
  // ********************************
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic cs_n_pin, serial_bit_clock, din_pin, res_mode_pin;
  logic shutdown_n_pin, dout_pin, dout_oe, busy_pin, busy_oe;
  logic sample_hold, powered;
  logic [3:0] mux_sel;
  logic [11:0] sample_code;
  int bad_count, checked, cyc;

  acpc_core dut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cs_n_pin(cs_n_pin), .serial_bit_clock(serial_bit_clock),
    .din_pin(din_pin), .res_mode_pin(res_mode_pin),
    .shutdown_n_pin(shutdown_n_pin), .sample_code(sample_code),
    .dout_pin(dout_pin), .dout_oe(dout_oe), .busy_pin(busy_pin),
    .busy_oe(busy_oe), .mux_sel(mux_sel), .sample_hold(sample_hold),
    .powered(powered));

  acpc_host_model host (.clk(clk), .dout_pin(dout_pin),
    .cs_n_pin(cs_n_pin), .serial_bit_clock(serial_bit_clock),
    .din_pin(din_pin));

  // 100 MHz system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ceiling far above the roughly 12000 cycles the scenarios need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count = bad_count + 1;
      results();
    end
  end

  // verdict and end of run
  task automatic results();
    if (bad_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // compare seen against expected, report at once on a difference
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer; waits for pready with no assumed latency
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // pop one result word and compare it
  task automatic rres(input logic [31:0] e);
    apb(1'b0, 8'h08, 32'h0);
    chk("result", rd, e);
  endtask

  // expected result word: valid, channel, short flag, zero-filled code
  function automatic logic [31:0] er(input logic [7:0] cb,
                                     input logic [11:0] c, input logic lo);
    return {16'h8000, cb[6:4], lo, lo ? {c[11:4], 4'h0} : c};
  endfunction

  function automatic logic [7:0] cbf(input int i, input logic lo);
    // input config opposite to resolution, so the two bits stay apart
    return {1'b1, 3'(i), lo, ~lo, 2'h3};
  endfunction

  function automatic logic [11:0] cwf(input int i);
    return 12'(12'h0f1 + i * 81);
  endfunction

  // new analog code ahead of the frame, taken at its hold
  task automatic conv(input logic [23:0] pat, input logic [11:0] c,
                      input int n);
    @(posedge clk);
    sample_code <= c;
    host.run(pat, n);
  endtask

  // frames len clocks apart with overlap; the tail lets the last finish
  task automatic burst(input logic lo, input int len, input int cnt);
    for (int i = 0; i < cnt; i++) conv({cbf(i, lo), 16'h0}, cwf(i), len);
    host.run(24'h0, 8);
    host.stop();
  endtask

  task automatic drain(input logic lo, input int cnt);
    for (int i = 0; i < cnt; i++) rres(er(cbf(i, lo), cwf(i), lo));
  endtask

  // ********************************
  // scenarios
  // ********************************
  initial begin
    cyc = 0;
    bad_count = 0;
    checked = 0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    res_mode_pin = 1'b0;
    shutdown_n_pin = 1'b1;
    sample_code = 12'h000;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    // reset values, unmapped access, empty result
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", rd, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    rres(32'h0);
    // leading zeros before the start bit, then a 24-clock frame
    conv({4'h0, 8'hd7, 12'h0}, 12'ha5c, 28);
    chk("mux", {28'h0, mux_sel}, 32'hb);
    chk("dout oe", {31'h0, dout_oe}, 32'h1);
    chk("busy oe", {31'h0, busy_oe}, 32'h1);
    chk("busy end", {31'h0, busy_pin}, 32'h0);
    chk("hold end", {31'h0, sample_hold}, 32'h0);
    chk("powered", {31'h0, powered}, 32'h1);
    chk("dout", {17'h0, host.rx[14:0]}, {17'h0, 12'ha5c, 3'h0});
    host.stop();
    chk("oe off", {30'h0, dout_oe, busy_oe}, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk("full pwr", {23'h0, rd[15:8], rd[0]}, {23'h0, 8'hd7, 1'b1});
    rres(er(8'hd7, 12'ha5c, 1'b0));
    // auto power-down with extreme codes, each wake giving a good result
    for (int i = 0; i < 2; i++) begin
      conv({8'ha0, 16'h0}, i ? 12'hfff : 12'h000, 24);
      host.stop();
      apb(1'b0, 8'h04, 32'h0);
      chk("auto sleep", {31'h0, rd[0]}, 32'h0);
      rres(er(8'ha0, i ? 12'hfff : 12'h000, 1'b0));
    end
    // short-mode request with the pin low, then high
    for (int p = 0; p < 2; p++) begin
      res_mode_pin <= p[0];
      conv({8'hbf, 16'h0}, 12'h9c7, 24);
      host.stop();
      chk("dout8", {17'h0, host.rx[14:0]}, p ? 32'h4e00 : 32'h4e38);
      rres(er(8'hbf, 12'h9c7, p[0]));
    end
    // 8-bit frames every 11 clocks
    burst(1'b1, 11, 3);
    drain(1'b1, 3);
    res_mode_pin <= 1'b0;
    // shutdown forces power off and refuses a start
    shutdown_n_pin <= 1'b0;
    repeat (8) @(posedge clk);
    conv({8'hd7, 16'h0}, 12'h123, 24);
    host.stop();
    apb(1'b0, 8'h04, 32'h0);
    chk("shutdown", {30'h0, rd[3], rd[0]}, 32'h0);
    chk("shutdown_n_pin pin", {31'h0, powered}, 32'h0);
    shutdown_n_pin <= 1'b1;
    repeat (8) @(posedge clk);
    // 15-clock frames fill the buffer; a further start is refused
    burst(1'b0, 15, 32);
    apb(1'b0, 8'h04, 32'h0);
    chk("fifo full", {30'h0, rd[4:3]}, 32'h1);
    conv({8'hd7, 16'h0}, 12'h777, 24);
    host.stop();
    drain(1'b0, 32);
    rres(32'h0);
    results();
  end
endmodule

// >>> verilog/acpc_core.sv
// serial conversion sequencer, power control, result fifo and apb slave
//
// Functional notes
// - new control byte may overlap shift-out, 15-clock pacing
// - power-down code 00 sleeps after each conversion
// - wake at conversion start, no wait
// - power-down code 11 stays powered always
// - result is unsigned straight binary code
// - 8-bit mode ends four clocks sooner
// - shutdown pin low powers down at once
// - input ignored until a high start bit
// - control byte msb first, fixed field layout
// - resolution pin low forces 12-bit conversions
// - hold, twelve converting clocks, thirteenth last bit
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps

// ********************************
// result fifo
// ********************************
module acpc_fifo #(
  parameter int unsigned W = 16,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  // whole fifo state, storage included
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } acpc_fifo_state_t;

  acpc_fifo_state_t f_q;
  acpc_fifo_state_t f_d;
  logic push;
  logic pop;

  // full and empty come from the count, so both are exact
  assign in_ready = f_q.cnt != (AW+1)'(DEPTH);
  assign out_valid = f_q.cnt != '0;
  assign out_data = f_q.mem[f_q.rp];

  // next state: write at head, read at tail
  always_comb begin
    f_d = f_q;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      f_d.mem[f_q.wp] = in_data;
      f_d.wp = f_q.wp + 1'b1;
    end
    if (pop) begin
      f_d.rp = f_q.rp + 1'b1;
    end
    if (push && !pop) begin
      f_d.cnt = f_q.cnt + 1'b1;
    end else if (pop && !push) begin
      f_d.cnt = f_q.cnt - 1'b1;
    end
  end

  // register the whole state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end
endmodule

// ********************************
// converter control top
// ********************************
module acpc_core (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cs_n_pin,
  input wire logic serial_bit_clock,
  input wire logic din_pin,
  input wire logic res_mode_pin,
  input wire logic shutdown_n_pin,
  input wire logic [11:0] sample_code,
  output logic dout_pin,
  output logic dout_oe,
  output logic busy_pin,
  output logic busy_oe,
  output logic [3:0] mux_sel,
  output logic sample_hold,
  output logic powered
);
  // all state of the block
  typedef struct packed {
    logic sclk_s1;          // pin synchronisers, first stages
    logic sclk_s2;
    logic sclk_s3;          // only for edge detection
    logic cs_s1;
    logic cs_s2;
    logic din_s1;
    logic din_s2;
    logic mode_s1;
    logic mode_s2;
    logic shutdown_n_pin_s1;
    logic shutdown_n_pin_s2;
    acpc_pkg::acpc_rx_state_t rx_state;
    logic [2:0] rx_cnt;     // control bits taken after start
    logic [5:0] rx_sh;      // control bits so far
    acpc_pkg::acpc_ctrl_byte_t cfg;
    logic conv_act;
    logic [3:0] conv_cnt;   // falling edges since hold
    logic [3:0] conv_len;
    logic [11:0] conv_sh;
    logic [11:0] code_q;    // held result
    logic push;
    logic powered;
    logic hold;
    logic dout;
    logic dout_oe;
    logic busy;
    logic busy_oe;
    logic [3:0] mux_sel;
    logic link_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } acpc_state_t;

  acpc_state_t s_q;
  acpc_state_t s_d;
  logic sclk_rise;
  logic sclk_fall;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [acpc_pkg::FIFO_W-1:0] fifo_out;
  acpc_pkg::acpc_result_t res_word;

  // result record of the finished conversion
  assign res_word = '{channel_select: s_q.cfg.channel_select,
                      res_low: s_q.conv_len == acpc_pkg::LOW_BITS,
                      code: s_q.code_q};

  acpc_fifo #(.W(acpc_pkg::FIFO_W), .DEPTH(acpc_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(s_q.push),
    .in_data(res_word),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out),
    .out_ready(fifo_pop)
  );

  // edges of the synchronised serial clock
  assign sclk_rise = s_q.sclk_s2 && !s_q.sclk_s3;
  assign sclk_fall = !s_q.sclk_s2 && s_q.sclk_s3;
  // pop only at the edge that completes a result read
  assign fifo_pop = psel && penable && s_q.pready && !pwrite &&
                    paddr == acpc_pkg::ADDR_RESULT;

  // length of a conversion from pin and control bit
  function automatic logic [3:0] conv_bits(input logic pin, input logic bit_);
    conv_bits = (pin && bit_) ? acpc_pkg::LOW_BITS : acpc_pkg::FULL_BITS;
  endfunction

  // ********************************
  // next state
  // ********************************
  always_comb begin
    s_d = s_q;
    // two flip-flops on every pin
    s_d.sclk_s1 = serial_bit_clock;
    s_d.sclk_s2 = s_q.sclk_s1;
    s_d.sclk_s3 = s_q.sclk_s2;
    s_d.cs_s1 = cs_n_pin;
    s_d.cs_s2 = s_q.cs_s1;
    s_d.din_s1 = din_pin;
    s_d.din_s2 = s_q.din_s1;
    s_d.mode_s1 = res_mode_pin;
    s_d.mode_s2 = s_q.mode_s1;
    s_d.shutdown_n_pin_s1 = shutdown_n_pin;
    s_d.shutdown_n_pin_s2 = s_q.shutdown_n_pin_s1;
    s_d.push = 1'b0;
    s_d.dout_oe = !s_q.cs_s2;
    s_d.busy_oe = !s_q.cs_s2;

    // control byte receiver, sampled on rising edges
    if (s_q.cs_s2) begin
      // chip select high drops a partial byte
      s_d.rx_state = acpc_pkg::RX_IDLE;
    end else if (sclk_rise) begin
      unique case (s_q.rx_state)
        acpc_pkg::RX_IDLE: begin
          // a start bit counts only when the result can be kept
          // and the running conversion is far enough along
          if (s_q.din_s2 && s_q.link_en && fifo_in_ready &&
              (!s_q.conv_act || s_q.conv_cnt >=
               s_q.conv_len - acpc_pkg::OVERLAP_BITS)) begin
            s_d.rx_state = acpc_pkg::RX_CTRL;
            s_d.rx_cnt = '0;
            s_d.powered = 1'b1;
          end
        end
        acpc_pkg::RX_CTRL: begin
          s_d.rx_sh = {s_q.rx_sh[4:0], s_q.din_s2};
          s_d.rx_cnt = s_q.rx_cnt + 1'b1;
          // mux follows the channel bits once they are known
          if (s_q.rx_cnt == 3'h3) begin
            s_d.mux_sel = {s_q.rx_sh[2:0], 1'b0};
            s_d.hold = 1'b0;
          end
          if (s_q.rx_cnt == acpc_pkg::CB_LAST_IDX) begin
            // byte complete: hold sample and start converting
            s_d.cfg = {1'b1, s_q.rx_sh, s_q.din_s2};
            s_d.mux_sel = {s_q.rx_sh[5:3], s_q.rx_sh[1]};
            s_d.rx_state = acpc_pkg::RX_IDLE;
            s_d.conv_act = 1'b1;
            s_d.conv_cnt = '0;
            s_d.hold = 1'b1;
            // resolution bit sits two places above the last bit taken
            s_d.conv_len = conv_bits(s_q.mode_s2, s_q.rx_sh[2]);
            // short codes keep the upper bits of the straight code
            if (conv_bits(s_q.mode_s2, s_q.rx_sh[2]) ==
                acpc_pkg::LOW_BITS) begin
              s_d.conv_sh = {sample_code[11:acpc_pkg::LOW_PAD],
                             acpc_pkg::LOW_PAD'(0)};
            end else begin
              s_d.conv_sh = sample_code;
            end
            s_d.code_q = s_d.conv_sh;
          end
        end
        default: begin
          s_d.rx_state = acpc_pkg::RX_IDLE;
        end
      endcase
    end

    // result shift-out, updated on falling edges
    if (sclk_fall && !s_q.cs_s2) begin
      if (s_q.conv_act) begin
        s_d.conv_cnt = s_q.conv_cnt + 1'b1;
        if (s_q.conv_cnt == '0) begin
          // first fall after hold: busy marks conversion start
          s_d.busy = 1'b1;
          s_d.dout = 1'b0;
        end else begin
          s_d.busy = 1'b0;
          s_d.dout = s_q.conv_sh[11];
          s_d.conv_sh = {s_q.conv_sh[10:0], 1'b0};
        end
        if (s_q.conv_cnt == s_q.conv_len) begin
          // last bit out: result stored, power as selected
          s_d.conv_act = 1'b0;
          s_d.hold = 1'b0;
          s_d.push = 1'b1;
          if (s_q.cfg.power_down_select == acpc_pkg::PD_AUTO) begin
            s_d.powered = 1'b0;
          end
          // code 11 and the reserved codes leave power on
        end
      end else begin
        // trailing clocks shift zeros
        s_d.dout = 1'b0;
        s_d.busy = 1'b0;
      end
    end

    // shutdown overrides power, conversion, result push, hold, busy and the receiver at once
    if (!s_q.shutdown_n_pin_s2) begin
      s_d.powered = 1'b0;
      s_d.conv_act = 1'b0;
      s_d.push = 1'b0;
      s_d.hold = 1'b0;
      s_d.busy = 1'b0;
      s_d.rx_state = acpc_pkg::RX_IDLE;
    end

    // apb slave: access phase lasts two cycles
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (psel && penable && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.prdata = '0;
      unique case (paddr)
        acpc_pkg::ADDR_CTRL: begin
          if (pwrite) begin
            s_d.link_en = pwdata[acpc_pkg::CTRL_LINK_EN];
          end
          s_d.prdata[acpc_pkg::CTRL_LINK_EN] = s_q.link_en;
        end
        acpc_pkg::ADDR_STATUS: begin
          s_d.prdata[acpc_pkg::ST_POWERED] = s_q.powered;
          s_d.prdata[acpc_pkg::ST_CONV] = s_q.conv_act;
          s_d.prdata[acpc_pkg::ST_RX] = s_q.rx_state == acpc_pkg::RX_CTRL;
          s_d.prdata[acpc_pkg::ST_VALID] = fifo_out_valid;
          s_d.prdata[acpc_pkg::ST_SPACE] = fifo_in_ready;
          s_d.prdata[acpc_pkg::ST_CFG_LO +: 8] = s_q.cfg;
        end
        acpc_pkg::ADDR_RESULT: begin
          // head of fifo; an empty fifo reads as zero
          if (fifo_out_valid) begin
            s_d.prdata[acpc_pkg::RES_VALID] = 1'b1;
            s_d.prdata[acpc_pkg::FIFO_W-1:0] = fifo_out;
          end
        end
        default: begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end

    if (!reset_n) begin
      s_d = '0;
      s_d.rx_state = acpc_pkg::RX_IDLE;
      s_d.link_en = acpc_pkg::CTRL_LINK_EN_RST;
      s_d.conv_len = acpc_pkg::FULL_BITS;
    end
  end

  // register the whole state (reset folded in above)
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // every output straight from a flip-flop
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign dout_pin = s_q.dout;
  assign dout_oe = s_q.dout_oe;
  assign busy_pin = s_q.busy;
  assign busy_oe = s_q.busy_oe;
  assign mux_sel = s_q.mux_sel;
  assign sample_hold = s_q.hold;
  assign powered = s_q.powered;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_conv_end;
    $fell(s_q.conv_act) && $past(s_q.shutdown_n_pin_s2);
  endsequence
  sequence s_byte_start;
    sclk_rise && !s_q.cs_s2 && s_q.shutdown_n_pin_s2 &&
      s_q.rx_state == acpc_pkg::RX_IDLE;
  endsequence

  a_auto_sleep: assert property (
    s_conv_end ##0 (s_q.cfg.power_down_select == acpc_pkg::PD_AUTO)
      |-> !s_q.powered && s_q.push)
    else $error("auto power-down missed");
  a_full_awake: assert property (
    s_conv_end ##0 (s_q.cfg.power_down_select == acpc_pkg::PD_FULL)
      |-> s_q.powered)
    else $error("full power mode slept");
  a_shutdown_n_pin_off: assert property (
    !s_q.shutdown_n_pin_s2 |=> !s_q.powered && !s_q.conv_act)
    else $error("shutdown ignored");
  a_wake_start: assert property (
    $rose(s_q.conv_act) |-> s_q.powered && s_q.hold)
    else $error("conversion began unpowered");
  a_start_ignore: assert property (
    s_byte_start ##0 !s_q.din_s2 |=> s_q.rx_state == acpc_pkg::RX_IDLE)
    else $error("low bit taken as start");
  a_res_length: assert property (
    $rose(s_q.conv_act) |-> s_q.conv_len ==
      (($past(s_q.mode_s2) && s_q.cfg.res_low) ?
       acpc_pkg::LOW_BITS : acpc_pkg::FULL_BITS))
    else $error("wrong conversion length");
  a_msb_out: assert property (
    sclk_fall && !s_q.cs_s2 && s_q.shutdown_n_pin_s2 && s_q.conv_act &&
      s_q.conv_cnt != '0 |=> s_q.dout == $past(s_q.conv_sh[11]))
    else $error("result bit order wrong");
  a_overlap_gate: assert property (
    s_byte_start ##1 (s_q.rx_state == acpc_pkg::RX_CTRL) |->
      !$past(s_q.conv_act) ||
      $past(s_q.conv_cnt) >= $past(s_q.conv_len) - acpc_pkg::OVERLAP_BITS)
    else $error("control byte too early");
  a_busy_mark: assert property (
    sclk_fall && !s_q.cs_s2 && s_q.shutdown_n_pin_s2 && s_q.conv_act &&
      s_q.conv_cnt == '0 |=> s_q.busy ##1 s_q.hold)
    else $error("busy not raised at hold");
endmodule

// >>> verilog/acpc_pkg.sv
// shared constants and types of the converter control block
package acpc_pkg;

  // ********************************
  // control byte and conversion
  // ********************************
  // control byte as it arrives, msb first
  typedef struct packed {
    logic start;           // always high
    logic [2:0] channel_select;
    logic res_low;         // high asks for the short conversion
    logic input_config_select;
    logic [1:0] power_down_select;
  } acpc_ctrl_byte_t;

  localparam logic [2:0] CB_LAST_IDX = 3'h6;   // seven bits follow start
  localparam logic [3:0] FULL_BITS = 4'hc;     // 12-bit result
  localparam logic [3:0] LOW_BITS = 4'h8;      // 8-bit result
  localparam logic [3:0] OVERLAP_BITS = 4'h4;  // early start of next byte
  localparam logic [1:0] PD_AUTO = 2'h0;       // sleep after each result
  localparam logic [1:0] PD_FULL = 2'h3;       // stay powered
  localparam int unsigned CODE_W = 12;
  localparam int unsigned LOW_PAD = 4;         // zero fill of short codes

  // one finished conversion as stored in the fifo
  typedef struct packed {
    logic [2:0] channel_select;
    logic res_low;
    logic [CODE_W-1:0] code;
  } acpc_result_t;

  localparam int unsigned FIFO_W = 16;
  localparam int unsigned FIFO_DEPTH = 32;

  // control byte receiver states, one-hot
  typedef enum logic [1:0] {
    RX_IDLE = 2'h1,
    RX_CTRL = 2'h2
  } acpc_rx_state_t;

  // ********************************
  // register map
  // ********************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam int unsigned CTRL_LINK_EN = 0;
  localparam logic CTRL_LINK_EN_RST = 1'h1;
  localparam int unsigned ST_POWERED = 0;
  localparam int unsigned ST_CONV = 1;
  localparam int unsigned ST_RX = 2;
  localparam int unsigned ST_VALID = 3;
  localparam int unsigned ST_SPACE = 4;
  localparam int unsigned ST_CFG_LO = 8;
  localparam int unsigned RES_VALID = 31;

endpackage
